/* File: rfs_pkg.sv */
// Overview of operation
// - mask bit 0 includes that rail's power good; mask bit 1 ignores it.
// - first mask bits 7,6,5 mask linear three, linear two, switch a1.
// - first mask bits 4..0 mask rails six, four, three, two, one.
// - second register bit 1 masks switch b2 shared good, bit 0 switch b1.
// - select bits 4:2 pick control input; code 101 ANDs inputs three and four.
// - select code 111 feeds constant one into the enable source mux.
// - bits 5:3 delay falling edge: 0,2,4,8,16,24,32,64 ms.
// - bits 2:0 delay rising edge with the same table; 000 means none.
// - delays may deviate ten percent; the tick base restarts at each edge.
// - delay code 110 gives 32 ms.
package rfs_pkg;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned CTL_W  = 6;
  localparam int unsigned PG_W   = 10;
  // register indices; byte address is four times the index
  localparam logic [5:0] IDX_PG_MASK = 6'h13;
  localparam logic [5:0] IDX_SEL     = 6'h14;
  localparam logic [5:0] IDX_DLY     = 6'h15;
  localparam logic [5:0] IDX_R6_MASK = 6'h16;
  localparam logic [5:0] IDX_STATUS  = 6'h20;
  localparam logic [7:0] RST_REG     = 8'h00;
  // field positions
  localparam int unsigned SEL_LSB  = 2;
  localparam int unsigned SEL_MSB  = 4;
  localparam int unsigned FALL_LSB = 3;
  localparam int unsigned FALL_MSB = 5;
  localparam int unsigned RISE_LSB = 0;
  localparam int unsigned RISE_MSB = 2;
  // enable source codes
  localparam logic [2:0] SEL_CONTROL_INPUT_ONE  = 3'h0;
  localparam logic [2:0] SEL_CONTROL_INPUT_TWO  = 3'h1;
  localparam logic [2:0] SEL_CONTROL_INPUT_FIVE  = 3'h2;
  localparam logic [2:0] SEL_CONTROL_INPUT_FOUR  = 3'h3;
  localparam logic [2:0] SEL_CONTROL_INPUT_THREE  = 3'h4;
  localparam logic [2:0] SEL_CTL34 = 3'h5;
  localparam logic [2:0] SEL_CONTROL_INPUT_SIX  = 3'h6;
  localparam logic [2:0] SEL_ONE   = 3'h7;
  // delay table in milliseconds
  localparam logic [6:0] DLY_MS [8] = '{7'h00, 7'h02, 7'h04, 7'h08,
                                        7'h10, 7'h18, 7'h20, 7'h40};
  // timing
  localparam int unsigned CLK_PERIOD_NS = 4;
  localparam int unsigned TICK_TIME_MS  = 1;
  localparam int unsigned TICK_CYCLES   =
    TICK_TIME_MS * 1000000 / CLK_PERIOD_NS;
endpackage

/* File: rfs_rail_five_enable.sv */
// Register access over Avalon-MM was decided locally.
`timescale 1ns/10ps
module rfs_rail_five_enable #(
  parameter int unsigned TICK_CYCLES = rfs_pkg::TICK_CYCLES
) (
  input  wire logic                       i_clk_sys,
  input  wire logic                       i_rst_n,
  input  wire logic [rfs_pkg::ADDR_W-1:0] i_avs_address,
  input  wire logic                       i_avs_read,
  input  wire logic                       i_avs_write,
  input  wire logic [3:0]                 i_avs_byteenable,
  input  wire logic [rfs_pkg::DATA_W-1:0] i_avs_writedata,
  output logic      [rfs_pkg::DATA_W-1:0] o_avs_readdata,
  output logic                            o_avs_waitrequest,
  input  wire logic [rfs_pkg::CTL_W-1:0]  i_control_input,
  input  wire logic [rfs_pkg::PG_W-1:0]   i_power_good,
  output logic                            o_rail_five_enable
);
  import rfs_pkg::*;

  localparam int unsigned PRE_W = $clog2(TICK_CYCLES + 1);
  localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(TICK_CYCLES - 1);

  typedef struct packed {
    logic [CTL_W-1:0]  ctl_meta;
    logic [CTL_W-1:0]  ctl_sync;
    logic [PG_W-1:0]   pg_meta;
    logic [PG_W-1:0]   pg_sync;
    logic [7:0]        pg_mask;
    logic [7:0]        sel_reg;
    logic [7:0]        dly_reg;
    logic [7:0]        r6_mask;
    logic              src_prev;
    logic              delayed;
    logic              running;
    logic [6:0]        ms_left;
    logic [PRE_W-1:0]  pre;
    logic              en;
    logic              wait_req;
    logic [DATA_W-1:0] rdata;
  } rfs_state_s;

  rfs_state_s state_r;
  rfs_state_s state_nxt;
  logic       src;
  logic       edge_seen;
  logic       pg_ok;
  logic [2:0] dly_code;
  logic [6:0] dly_ms;
  logic       req;

  ////////////////////////////////////////////////////////////////////////////
  // enable source mux
  function automatic logic sel_src(input logic [2:0] code,
                                   input logic [CTL_W-1:0] ctl);
    logic r;
    r = 1'b0;
    unique case (code)
      SEL_CONTROL_INPUT_ONE:  r = ctl[0];
      SEL_CONTROL_INPUT_TWO:  r = ctl[1];
      SEL_CONTROL_INPUT_FIVE:  r = ctl[4];
      SEL_CONTROL_INPUT_FOUR:  r = ctl[3];
      SEL_CONTROL_INPUT_THREE:  r = ctl[2];
      SEL_CTL34: r = ctl[2] & ctl[3];
      SEL_CONTROL_INPUT_SIX:  r = ctl[5];
      SEL_ONE:   r = 1'b1;
    endcase
    return r;
  endfunction

  function automatic logic [7:0] reg_read(input logic [5:0] idx,
                                          input rfs_state_s s);
    logic [7:0] r;
    r = 8'h00;
    unique case (idx)
      IDX_PG_MASK: r = s.pg_mask;
      IDX_SEL:     r = {3'h0, s.sel_reg[4:0]};
      IDX_DLY:     r = {2'h0, s.dly_reg[5:0]};
      IDX_R6_MASK: r = s.r6_mask;
      IDX_STATUS:  r = {4'h0, s.src_prev, s.running, s.delayed, s.en};
      default:     r = 8'h00;
    endcase
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    state_nxt = state_r;
    state_nxt.ctl_meta = i_control_input;
    state_nxt.ctl_sync = state_r.ctl_meta;
    state_nxt.pg_meta  = i_power_good;
    state_nxt.pg_sync  = state_r.pg_meta;
    src = sel_src(state_r.sel_reg[SEL_MSB:SEL_LSB],
                  state_r.ctl_sync);
    // mask bit one drops that power good from the AND
    pg_ok = &(state_r.pg_sync |
              {state_r.sel_reg[1:0], state_r.pg_mask});
    dly_code = src ? state_r.dly_reg[RISE_MSB:RISE_LSB]
                   : state_r.dly_reg[FALL_MSB:FALL_LSB];
    dly_ms = DLY_MS[dly_code];
    edge_seen = (src != state_r.src_prev);
    state_nxt.src_prev = src;
    if (edge_seen) begin
      state_nxt.pre = '0;
      if (src == state_r.delayed) begin
        state_nxt.running = 1'b0;
      end else if (dly_ms == 7'h00) begin
        state_nxt.delayed = src;
        state_nxt.running = 1'b0;
      end else begin
        state_nxt.running = 1'b1;
        state_nxt.ms_left = dly_ms;
      end
    end else if (state_r.running) begin
      if (state_r.pre == PRE_LAST) begin
        state_nxt.pre = '0;
        if (state_r.ms_left == 7'h01) begin
          state_nxt.delayed = src;
          state_nxt.running = 1'b0;
          state_nxt.ms_left = 7'h00;
        end else begin
          state_nxt.ms_left = state_r.ms_left - 7'h01;
        end
      end else begin
        state_nxt.pre = state_r.pre + PRE_W'(1);
      end
    end
    state_nxt.en = state_r.delayed & pg_ok;
    // avalon slave: answer one cycle after the request is seen
    req = i_avs_read | i_avs_write;
    state_nxt.wait_req = !(req && state_r.wait_req);
    if (req && state_r.wait_req) begin
      state_nxt.rdata = i_avs_read ?
        {24'h0, reg_read(i_avs_address[7:2], state_r)} : '0;
    end
    if (i_avs_write && !state_r.wait_req && i_avs_byteenable[0]) begin
      unique case (i_avs_address[7:2])
        IDX_PG_MASK: state_nxt.pg_mask = i_avs_writedata[7:0];
        IDX_SEL:     state_nxt.sel_reg = {3'h0, i_avs_writedata[4:0]};
        IDX_DLY:     state_nxt.dly_reg = {2'h0, i_avs_writedata[5:0]};
        IDX_R6_MASK: state_nxt.r6_mask = i_avs_writedata[7:0];
        default:     ;
      endcase
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      state_r          <= '0;
      state_r.pg_mask  <= RST_REG;
      state_r.sel_reg  <= RST_REG;
      state_r.dly_reg  <= RST_REG;
      state_r.r6_mask  <= RST_REG;
      state_r.wait_req <= 1'b1;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign o_avs_readdata     = state_r.rdata;
  assign o_avs_waitrequest  = state_r.wait_req;
  assign o_rail_five_enable = state_r.en;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);

  AST_BUS_ONE_CYCLE: assert property (
    (i_avs_read || i_avs_write) && o_avs_waitrequest
      |=> !o_avs_waitrequest ##1 o_avs_waitrequest)
    else $error("waitrequest not low for exactly one cycle");
  AST_PG_BLOCKS: assert property (!pg_ok |=> !o_rail_five_enable)
    else $error("enable high with unmasked power good low");
  AST_LIN3_MAP: assert property (
    !state_r.pg_sync[7] && !state_r.pg_mask[7] |=> !o_rail_five_enable)
    else $error("linear three power good not gating enable");
  AST_RAIL6_MAP: assert property (
    !state_r.pg_sync[4] && !state_r.pg_mask[4] |=> !o_rail_five_enable)
    else $error("rail six power good not gating enable");
  AST_SWB2_MAP: assert property (
    !state_r.pg_sync[9] && !state_r.sel_reg[1] |=> !o_rail_five_enable)
    else $error("switch b2 shared good not gating enable");
  AST_SEL_PAIR: assert property (
    state_r.sel_reg[4:2] == SEL_CTL34
      |-> src == (state_r.ctl_sync[2] & state_r.ctl_sync[3]))
    else $error("code 101 not the AND of inputs three and four");
  AST_SEL_ONE: assert property (
    state_r.sel_reg[4:2] == SEL_ONE |-> src)
    else $error("code 111 does not force the source high");
  AST_FALL_64: assert property (
    edge_seen && !src && state_r.delayed && dly_code == 3'h7
      |=> state_r.running && state_r.ms_left == 7'h40)
    else $error("falling delay code 111 not 64 ms");
  AST_RISE_NONE: assert property (
    edge_seen && src && state_r.dly_reg[2:0] == 3'h0 |=> state_r.delayed)
    else $error("rising edge delayed with code 000");
  AST_TICK_HOLD: assert property (
    state_r.running && !edge_seen && state_r.pre != PRE_LAST
      |=> $stable(state_r.ms_left) && $stable(state_r.delayed))
    else $error("delay count moved between ticks");
  AST_CODE_110: assert property (
    edge_seen && src != state_r.delayed && dly_code == 3'h6
      |=> state_r.ms_left == 7'h20)
    else $error("delay code 110 not 32 ms");
  AST_EN_SRC: assert property (
    o_rail_five_enable |-> $past(state_r.delayed))
    else $error("enable high without delayed source");
  AST_RESTART: assert property (
    edge_seen && state_r.running && src != state_r.delayed && dly_ms != 0
      |=> state_r.pre == '0 && state_r.ms_left == $past(dly_ms))
    else $error("new edge did not restart the delay");

  ////////////////////////////////////////////////////////////////////////////
  // power good mapping, one unmasked low input at a time
  AST_PG_PASS: assert property (
    state_r.delayed &&
    (state_r.pg_sync | {state_r.sel_reg[1:0], state_r.pg_mask}) == 10'h3ff
      |=> o_rail_five_enable)
    else $error("enable low with every power good met");
  AST_LIN2_MAP: assert property (
    !state_r.pg_sync[6] && !state_r.pg_mask[6] |=> !o_rail_five_enable)
    else $error("linear two power good not gating enable");
  AST_GROUP_A_SWITCH_ONE_MAP: assert property (
    !state_r.pg_sync[5] && !state_r.pg_mask[5] |=> !o_rail_five_enable)
    else $error("switch a1 power good not gating enable");
  AST_RAIL4_MAP: assert property (
    !state_r.pg_sync[3] && !state_r.pg_mask[3] |=> !o_rail_five_enable)
    else $error("rail four power good not gating enable");
  AST_RAIL3_MAP: assert property (
    !state_r.pg_sync[2] && !state_r.pg_mask[2] |=> !o_rail_five_enable)
    else $error("rail three power good not gating enable");
  AST_RAIL2_MAP: assert property (
    !state_r.pg_sync[1] && !state_r.pg_mask[1] |=> !o_rail_five_enable)
    else $error("rail two power good not gating enable");
  AST_RAIL1_MAP: assert property (
    !state_r.pg_sync[0] && !state_r.pg_mask[0] |=> !o_rail_five_enable)
    else $error("rail one power good not gating enable");
  AST_GROUP_B_SWITCH_ONE_MAP: assert property (
    !state_r.pg_sync[8] && !state_r.sel_reg[0] |=> !o_rail_five_enable)
    else $error("switch b1 power good not gating enable");

  ////////////////////////////////////////////////////////////////////////////
  // enable source per select code
  AST_SEL_IN1: assert property (
    state_r.sel_reg[4:2] == 3'h0 |-> src == state_r.ctl_sync[0])
    else $error("code 000 does not pick control input one");
  AST_SEL_IN2: assert property (
    state_r.sel_reg[4:2] == 3'h1 |-> src == state_r.ctl_sync[1])
    else $error("code 001 does not pick control input two");
  AST_SEL_IN5: assert property (
    state_r.sel_reg[4:2] == 3'h2 |-> src == state_r.ctl_sync[4])
    else $error("code 010 does not pick control input five");
  AST_SEL_IN4: assert property (
    state_r.sel_reg[4:2] == 3'h3 |-> src == state_r.ctl_sync[3])
    else $error("code 011 does not pick control input four");
  AST_SEL_IN3: assert property (
    state_r.sel_reg[4:2] == 3'h4 |-> src == state_r.ctl_sync[2])
    else $error("code 100 does not pick control input three");
  AST_SEL_IN6: assert property (
    state_r.sel_reg[4:2] == 3'h6 |-> src == state_r.ctl_sync[5])
    else $error("code 110 does not pick control input six");

  ////////////////////////////////////////////////////////////////////////////
  // delay table, both edge directions
  AST_CODE_001: assert property (
    edge_seen && src != state_r.delayed && dly_code == 3'h1
      |=> state_r.running && state_r.ms_left == 7'h02)
    else $error("delay code 001 not 2 ms");
  AST_CODE_010: assert property (
    edge_seen && src != state_r.delayed && dly_code == 3'h2
      |=> state_r.running && state_r.ms_left == 7'h04)
    else $error("delay code 010 not 4 ms");
  AST_CODE_011: assert property (
    edge_seen && src != state_r.delayed && dly_code == 3'h3
      |=> state_r.running && state_r.ms_left == 7'h08)
    else $error("delay code 011 not 8 ms");
  AST_CODE_100: assert property (
    edge_seen && src != state_r.delayed && dly_code == 3'h4
      |=> state_r.running && state_r.ms_left == 7'h10)
    else $error("delay code 100 not 16 ms");
  AST_CODE_101: assert property (
    edge_seen && src != state_r.delayed && dly_code == 3'h5
      |=> state_r.running && state_r.ms_left == 7'h18)
    else $error("delay code 101 not 24 ms");
  AST_TICK_STEP: assert property (
    state_r.running && !edge_seen && state_r.pre == PRE_LAST &&
    state_r.ms_left != 7'h01
      |=> state_r.ms_left == $past(state_r.ms_left) - 7'h01)
    else $error("delay count did not step at the tick");
  AST_DELAY_DONE: assert property (
    state_r.running && !edge_seen && state_r.pre == PRE_LAST &&
    state_r.ms_left == 7'h01
      |=> !state_r.running && state_r.delayed == $past(src))
    else $error("delay end did not pass the source on");
  AST_CANCEL: assert property (
    edge_seen && src == state_r.delayed |=> !state_r.running)
    else $error("return to the old level did not cancel the delay");

  COV_WRITE: cover property (i_avs_write && !o_avs_waitrequest);
  COV_DELAY_DONE: cover property (state_r.running ##1 !state_r.running);
  COV_RESTART: cover property (state_r.running && edge_seen);
  COV_ENABLE: cover property ($rose(o_rail_five_enable));
  COV_PAIR_SEL: cover property (state_r.sel_reg[4:2] == SEL_CTL34 && src);
endmodule

/* File: rfs_rail_five_enable_bench.sv */
`timescale 1ns/10ps
module rfs_rail_five_enable_bench;
  import rfs_pkg::*;
  localparam int unsigned TICK = 10;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic        rd = 1'b0;
  logic        wr = 1'b0;
  logic [31:0] wd = 32'h0;
  logic [31:0] q;
  logic        wt;
  logic [5:0]  ctl = 6'h00;
  logic [9:0]  pg = 10'h3ff;
  logic        en;
  logic [31:0] v;
  int          n_errors = 0;
  int          tests_run = 0;
  int          cyc_n = 0;
  int          ms [8] = '{0, 2, 4, 8, 16, 24, 32, 64};
  logic [5:0]  pin [8] = '{6'h01, 6'h02, 6'h10, 6'h08, 6'h04, 6'h0c,
                           6'h20, 6'h00};
  rfs_rail_five_enable #(.TICK_CYCLES(TICK)) rfs_rail_five_enable_i (
    .i_clk_sys(clk), .i_rst_n(rst_n), .i_avs_address(adr),
    .i_avs_read(rd), .i_avs_write(wr), .i_avs_byteenable(4'hf),
    .i_avs_writedata(wd), .o_avs_readdata(q), .o_avs_waitrequest(wt),
    .i_control_input(ctl), .i_power_good(pg), .o_rail_five_enable(en));
  always #2 clk = ~clk;
  ////////////////////////////////////////////////////////////////////
  task automatic results();
    $display("tests %0d errors %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == 20000) begin
      n_errors++;
      results();
    end
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic cy(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [7:0] d, output logic [31:0] r);
    @(posedge clk);
    rd <= !w;
    wr <= w;
    adr <= a;
    wd <= {24'h0, d};
    do @(posedge clk); while (wt !== 1'b0);
    r = q;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00, v);
    chk(v, {24'h0, e});
  endtask
  ////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    foreach (ms[i]) if (i < 4) rchk(8'h4c + 8'(4 * i), 8'h00);
    bus(1'b1, 8'h4c, 8'ha5, v);
    rchk(8'h4c, 8'ha5);
    bus(1'b1, 8'h50, 8'hff, v);
    rchk(8'h50, 8'h1f);
    bus(1'b1, 8'h54, 8'hff, v);
    rchk(8'h54, 8'h3f);
    bus(1'b1, 8'h58, 8'h5a, v);
    rchk(8'h58, 8'h5a);
    bus(1'b1, 8'h60, 8'h77, v);
    rchk(8'h60, 8'h00);
    bus(1'b1, 8'h4c, 8'h00, v);
    bus(1'b1, 8'h54, 8'h00, v);
    $display("test regs done");
  endtask
  task automatic t_sel();
    for (int c = 0; c < 8; c++) begin
      bus(1'b1, 8'h50, 8'(c << 2), v);
      ctl <= ~pin[c];
      cy(8);
      chk(en, c == 7);
      if (c == 5) begin
        ctl <= 6'h04;
        cy(8);
        chk(en, 1'b0);
      end
      ctl <= pin[c];
      cy(8);
      chk(en, 1'b1);
    end
    $display("test select done");
  endtask
  task automatic t_pg();
    for (int i = 0; i < 10; i++) begin
      bus(1'b1, 8'h4c, 8'h00, v);
      bus(1'b1, 8'h50, 8'h1c, v);
      pg <= ~(10'h1 << i);
      cy(8);
      chk(en, 1'b0);
      bus(1'b1, 8'h4c, (i < 8) ? 8'(1 << i) : 8'h00, v);
      bus(1'b1, 8'h50, 8'h1c | 8'(i == 8) | ((i == 9) ? 8'h02 : 8'h00), v);
      cy(8);
      chk(en, 1'b1);
    end
    pg <= 10'h3ff;
    $display("test power good done");
  endtask
  task automatic t_dly();
    int n;
    bus(1'b1, 8'h4c, 8'h00, v);
    bus(1'b1, 8'h50, 8'h00, v);
    for (int c = 0; c < 8; c++) begin
      bus(1'b1, 8'h54, 8'((c << 3) | c), v);
      n = ms[c] * TICK;
      for (int d = 0; d < 2; d++) begin
        ctl <= (d == 0) ? 6'h01 : 6'h00;
        cy(n * 85 / 100);
        if (n > 0) chk(en, d == 1);
        cy(n * 25 / 100 + 8);
        chk(en, d == 0);
      end
    end
    bus(1'b1, 8'h54, 8'h02, v);
    ctl <= 6'h01;
    cy(20);
    ctl <= 6'h00;
    cy(4);
    ctl <= 6'h01;
    cy(30);
    chk(en, 1'b0);
    rchk(8'h80, 8'h0c);
    cy(20);
    chk(en, 1'b1);
    rchk(8'h80, 8'h0b);
    $display("test delays done");
  endtask
  initial begin
    cy(6);
    rst_n <= 1'b1;
    t_regs();
    t_sel();
    t_pg();
    t_dly();
    results();
  end
endmodule
